// ==== rtl/ssr_status_service.sv ====
// Status byte, masks, latched trip register and service request generation.
`default_nettype none
module ssr_status_service
    import ssr_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire ssr_cmd_t   i_cmd,
    input  wire ssr_cond_t  i_cond,
    input  wire logic       i_prog_done,
    input  wire logic       i_cmd_fault,
    input  wire logic [7:0] i_fault_code,
    input  wire logic       i_chain_req,
    input  wire logic       i_bus_clear,
    input  wire logic       i_poll_ack,
    output logic [7:0]      o_rdata,
    output logic            o_rvalid,
    output logic            o_service_pending
);
    ////////////////////////////////////////////////////////////////////////////
    ssr_state_t st_reg;
    ssr_state_t st_next;
    logic [7:0] live_vec;
    logic [7:0] status_byte;
    logic       trip_summary_flag;
    logic       service_req;

    function automatic logic [7:0] cond_vec(input ssr_cond_t c);
        logic [7:0] v;
        v = ZERO_BYTE;
        v[BIT_OVERVOLT]  = c.overvoltage_trip;
        v[BIT_DLY_CLAMP] = c.delayed_clamp_trip;
        v[BIT_OVERHEAT]  = c.overheat_trip;
        v[BIT_CLAMP]     = c.clamp_trip;
        return v;
    endfunction

    assign live_vec          = cond_vec(i_cond);
    assign trip_summary_flag = |(st_reg.trip_latch_reg & st_reg.trip_en_reg & TRIP_DEFINED);
    assign service_req = (st_reg.service_en_reg[BIT_TRIP_SUM] & trip_summary_flag)
                       | (st_reg.service_en_reg[BIT_PROG_DONE] & st_reg.prog_done_reg)
                       | (st_reg.service_en_reg[BIT_CMD_FAULT] & (st_reg.error_reg != ZERO_BYTE))
                       | (st_reg.service_en_reg[BIT_CHAIN] & i_chain_req);

    always_comb begin
        status_byte                = ZERO_BYTE;
        status_byte[BIT_TRIP_SUM]  = trip_summary_flag;
        status_byte[BIT_POWERUP]   = st_reg.powerup_reg;
        status_byte[BIT_PROG_DONE] = st_reg.prog_done_reg;
        status_byte[BIT_CMD_FAULT] = st_reg.error_reg != ZERO_BYTE;
        status_byte[BIT_CHAIN]     = i_chain_req;
        status_byte[BIT_SERVICE]   = service_req;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.rvalid_reg = 1'b0;
        if (i_poll_ack) begin
            st_next.powerup_reg   = 1'b0;
            st_next.prog_done_reg = 1'b0;
        end
        if (i_cmd.wr) begin
            if (i_cmd.sel == SEL_SERVICE_EN) begin
                st_next.service_en_reg = i_cmd.wdata & SERVICE_DEFINED;
            end
            if (i_cmd.sel == SEL_TRIP_EN) begin
                st_next.trip_en_reg = i_cmd.wdata & TRIP_DEFINED;
            end
        end
        if (i_cmd.rd) begin
            st_next.rvalid_reg = 1'b1;
            unique case (i_cmd.sel)
                SEL_STATUS_BYTE: st_next.rdata_reg = status_byte;
                SEL_SERVICE_EN:  st_next.rdata_reg = st_reg.service_en_reg;
                SEL_TRIP_LATCH: begin
                    st_next.rdata_reg      = st_reg.trip_latch_reg;
                    st_next.trip_latch_reg = ZERO_BYTE;
                end
                SEL_TRIP_EN:     st_next.rdata_reg = st_reg.trip_en_reg;
                SEL_LIVE:        st_next.rdata_reg = live_vec;
                SEL_ERROR: begin
                    st_next.rdata_reg = st_reg.error_reg;
                    st_next.error_reg = ZERO_BYTE;
                end
                default:         st_next.rdata_reg = ZERO_BYTE;
            endcase
        end
        if (i_bus_clear) begin
            st_next.error_reg = ZERO_BYTE;
        end
        // Events arriving alongside a clear win over it.
        st_next.trip_latch_reg = st_next.trip_latch_reg | live_vec;
        if (i_cmd_fault) begin
            st_next.error_reg = i_fault_code;
        end
        if (i_prog_done) begin
            st_next.prog_done_reg = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= '{service_en_reg: ZERO_BYTE, trip_en_reg: ZERO_BYTE, trip_latch_reg: ZERO_BYTE,
                        error_reg: ZERO_BYTE, prog_done_reg: 1'b0, powerup_reg: 1'b1,
                        rdata_reg: ZERO_BYTE, rvalid_reg: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata           = st_reg.rdata_reg;
    assign o_rvalid          = st_reg.rvalid_reg;
    assign o_service_pending = service_req;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_trip_query;
        i_cmd.rd && i_cmd.sel == SEL_TRIP_LATCH;
    endsequence

    property p_trip_service;
        st_reg.service_en_reg[BIT_TRIP_SUM] && |(st_reg.trip_latch_reg & st_reg.trip_en_reg) |-> o_service_pending;
    endproperty
    a_trip_service: assert property (p_trip_service) else $error("trip did not raise request");

    property p_prog_service;
        i_prog_done && st_reg.service_en_reg[BIT_PROG_DONE] && !(i_cmd.wr && i_cmd.sel == SEL_SERVICE_EN)
            |=> o_service_pending;
    endproperty
    a_prog_service: assert property (p_prog_service) else $error("program finish did not raise request");

    property p_fault_service;
        i_cmd_fault && i_fault_code != ZERO_BYTE && st_reg.service_en_reg[BIT_CMD_FAULT]
            && !(i_cmd.wr && i_cmd.sel == SEL_SERVICE_EN) |=> o_service_pending;
    endproperty
    a_fault_service: assert property (p_fault_service) else $error("command fault did not raise request");

    property p_latch_hold;
        live_vec != ZERO_BYTE ##1 (live_vec == ZERO_BYTE && !(i_cmd.rd && i_cmd.sel == SEL_TRIP_LATCH))
            |=> st_reg.trip_latch_reg != ZERO_BYTE;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("trip bit lost without query");

    property p_query_clear;
        s_trip_query ##0 live_vec == ZERO_BYTE |=> st_reg.trip_latch_reg == ZERO_BYTE && o_rvalid
            && o_rdata == $past(st_reg.trip_latch_reg);
    endproperty
    a_query_clear: assert property (p_query_clear) else $error("trip query did not return and clear");

    property p_trip_mask;
        st_reg.trip_en_reg == ZERO_BYTE |-> !trip_summary_flag;
    endproperty
    a_trip_mask: assert property (p_trip_mask) else $error("masked trip reached summary");

    property p_error_clear;
        (i_bus_clear || (i_cmd.rd && i_cmd.sel == SEL_ERROR)) && !i_cmd_fault |=> st_reg.error_reg == ZERO_BYTE;
    endproperty
    a_error_clear: assert property (p_error_clear) else $error("error register not cleared");

    property p_summary_bit;
        i_cmd.rd && i_cmd.sel == SEL_STATUS_BYTE |=> o_rdata[BIT_TRIP_SUM] == $past(trip_summary_flag);
    endproperty
    a_summary_bit: assert property (p_summary_bit) else $error("status bit 0 wrong");

    property p_live_read;
        i_cmd.rd && i_cmd.sel == SEL_LIVE |=> o_rdata == ($past(live_vec) & TRIP_DEFINED);
    endproperty
    a_live_read: assert property (p_live_read) else $error("live register read wrong");

    property p_trip_set;
        live_vec != ZERO_BYTE |=> (st_reg.trip_latch_reg & $past(live_vec)) == $past(live_vec);
    endproperty
    a_trip_set: assert property (p_trip_set) else $error("trip condition not latched");

    property p_read_answer;
        i_cmd.rd |=> o_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read gave no answer");

    property p_no_stray_answer;
        !i_cmd.rd |=> !o_rvalid;
    endproperty
    a_no_stray_answer: assert property (p_no_stray_answer) else $error("answer without a read");

    property p_service_masked;
        st_reg.service_en_reg == ZERO_BYTE |-> !o_service_pending;
    endproperty
    a_service_masked: assert property (p_service_masked) else $error("request with mask clear");

    property p_overvolt_enable;
        st_reg.trip_latch_reg[BIT_OVERVOLT] && st_reg.trip_en_reg[BIT_OVERVOLT] |-> trip_summary_flag;
    endproperty
    a_overvolt_enable: assert property (p_overvolt_enable) else $error("overvoltage trip not summed");

    property p_dly_clamp_enable;
        st_reg.trip_latch_reg[BIT_DLY_CLAMP] && st_reg.trip_en_reg[BIT_DLY_CLAMP] |-> trip_summary_flag;
    endproperty
    a_dly_clamp_enable: assert property (p_dly_clamp_enable) else $error("delayed clamp trip not summed");

    property p_overheat_enable;
        st_reg.trip_latch_reg[BIT_OVERHEAT] && st_reg.trip_en_reg[BIT_OVERHEAT] |-> trip_summary_flag;
    endproperty
    a_overheat_enable: assert property (p_overheat_enable) else $error("overheat trip not summed");

    property p_clamp_enable;
        st_reg.trip_latch_reg[BIT_CLAMP] && st_reg.trip_en_reg[BIT_CLAMP] |-> trip_summary_flag;
    endproperty
    a_clamp_enable: assert property (p_clamp_enable) else $error("clamp trip not summed");
endmodule
`default_nettype wire

// ==== rtl/ssr_pkg.sv ====
// Package of constants and carrier types for the status and service-request block.
`default_nettype none
package ssr_pkg;
    localparam int unsigned REG_W = 8;
    // Register selects for the command port.
    localparam logic [2:0] SEL_STATUS_BYTE = 3'h0;
    localparam logic [2:0] SEL_SERVICE_EN  = 3'h1;
    localparam logic [2:0] SEL_TRIP_LATCH  = 3'h2;
    localparam logic [2:0] SEL_TRIP_EN     = 3'h3;
    localparam logic [2:0] SEL_LIVE        = 3'h4;
    localparam logic [2:0] SEL_ERROR       = 3'h5;
    // Field positions.
    localparam int unsigned BIT_TRIP_SUM   = 0;
    localparam int unsigned BIT_POWERUP    = 1;
    localparam int unsigned BIT_PROG_DONE  = 2;
    localparam int unsigned BIT_CMD_FAULT  = 3;
    localparam int unsigned BIT_CHAIN      = 4;
    localparam int unsigned BIT_SERVICE    = 6;
    localparam int unsigned BIT_OVERVOLT   = 0;
    localparam int unsigned BIT_DLY_CLAMP  = 1;
    localparam int unsigned BIT_OVERHEAT   = 2;
    localparam int unsigned BIT_CLAMP      = 6;
    localparam logic [7:0] TRIP_DEFINED    = 8'h47;
    localparam logic [7:0] SERVICE_DEFINED = 8'h1d;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;

    typedef struct packed {
        logic       overvoltage_trip;
        logic       delayed_clamp_trip;
        logic       overheat_trip;
        logic       clamp_trip;
    } ssr_cond_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] sel;
        logic [7:0] wdata;
    } ssr_cmd_t;

    typedef struct packed {
        logic [7:0] service_en_reg;
        logic [7:0] trip_en_reg;
        logic [7:0] trip_latch_reg;
        logic [7:0] error_reg;
        logic       prog_done_reg;
        logic       powerup_reg;
        logic [7:0] rdata_reg;
        logic       rvalid_reg;
    } ssr_state_t;
endpackage
`default_nettype wire

// ==== sim/ssr_ctrl_model.sv ====
// Remote controller model that forwards commands and keeps unused mask bits at zero.
`default_nettype none
module ssr_ctrl_model
    import ssr_pkg::*;
(
    input  wire ssr_cmd_t i_req,
    output ssr_cmd_t      o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        o_cmd = i_req;
        if (i_req.sel == SEL_SERVICE_EN) begin
            o_cmd.wdata = i_req.wdata & SERVICE_DEFINED;
        end else if (i_req.sel == SEL_TRIP_EN) begin
            o_cmd.wdata = i_req.wdata & TRIP_DEFINED;
        end
    end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench with a reference model of the status and service-request block.
`default_nettype none
module testbench;
    import ssr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_clk, i_sys_rst, prog, fault, chain, bclr, ack, rvalid, pend;
    logic [7:0] code, rdata;
    ssr_cmd_t   req, cmd;
    ssr_cond_t  cond;
    int         failures, samples_checked;
    int         svc, ten, lat, err, pd, pu, erv, erd, live;
    ssr_ctrl_model ssr_ctrl_model_i (.i_req(req), .o_cmd(cmd));
    ssr_status_service ssr_status_service_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd(cmd),
        .i_cond(cond), .i_prog_done(prog), .i_cmd_fault(fault), .i_fault_code(code),
        .i_chain_req(chain), .i_bus_clear(bclr), .i_poll_ack(ack), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_service_pending(pend));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Status byte as the model sees it; bit 6 is the pending service request.
    function automatic int stat(input logic ch);
        int s;
        s = int'((lat & ten) != 0) | (pu << 1) | (pd << 2) | (int'(err != 0) << 3) | (int'(ch) << 4);
        return s | (int'((s & svc & 8'h1d) != 0) << 6);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        {prog, fault, chain, bclr, ack, code, req, cond} = '0;
        {failures, samples_checked, svc, ten, lat, err, pd, erv, erd} = '0;
        pu = 1;
        i_sys_rst = 1'b1;
        void'($urandom(53));
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        check(rdata, 8'h00);
        check({7'h00, rvalid}, 8'h00);
        check({7'h00, pend}, 8'h00);
        $display("reset test done");
        for (int n = 0; n < 4000; n++) begin
            @(negedge i_clk);
            check({7'h00, rvalid}, 8'(erv));
            if (erv != 0) check(rdata, 8'(erd));
            check({7'h00, pend}, 8'(stat(chain) >> 6));
            req.rd = ($urandom % 3) == 1;
            req.wr = !req.rd && ($urandom % 2);
            req.sel = 3'($urandom % 8);
            req.wdata = 8'($urandom);
            cond = ssr_cond_t'(4'($urandom & $urandom & $urandom));
            prog = ($urandom % 16) == 0;
            fault = ($urandom % 24) == 0;
            code = 8'($urandom);
            chain = ($urandom % 8) == 0;
            bclr = ($urandom % 24) == 0;
            ack = ($urandom % 20) == 0;
            live = (int'(cond.clamp_trip) << 6) | (int'(cond.overheat_trip) << 2);
            live = live | (int'(cond.delayed_clamp_trip) << 1) | int'(cond.overvoltage_trip);
            erv = int'(req.rd);
            case (req.sel)
                SEL_STATUS_BYTE: erd = stat(chain);
                SEL_SERVICE_EN:  erd = svc;
                SEL_TRIP_LATCH:  erd = lat;
                SEL_TRIP_EN:     erd = ten;
                SEL_LIVE:        erd = live;
                SEL_ERROR:       erd = err;
                default:         erd = 0;
            endcase
            if (req.wr && req.sel == SEL_SERVICE_EN) svc = req.wdata & 8'h1d;
            if (req.wr && req.sel == SEL_TRIP_EN) ten = req.wdata & 8'h47;
            lat = ((req.rd && req.sel == SEL_TRIP_LATCH) ? 0 : lat) | live;
            err = fault ? int'(code) : ((bclr || (req.rd && req.sel == SEL_ERROR)) ? 0 : err);
            pd = int'(prog) | (pd & int'(!ack));
            pu = pu & int'(!ack);
        end
        $display("random traffic test done");
        end_sim();
    end
endmodule
`default_nettype wire
